// File: spi_pkg.sv
/*
 * Shared constants for the serial port: register map, field positions,
 * reset values, operating modes and clock divider counts.
 * Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package spi_pkg;

	// ==========================================================
	// Widths
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int ADDR_W     = 8;
	localparam int EDGE_W     = 4;
	localparam int DIV_W      = 9;

	// ==========================================================
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CON1   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CON3   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DATA   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_RELOAD = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EVENT  = 8'h14;

	// ==========================================================
	// Field positions
	localparam int STAT_SMP  = 7;
	localparam int STAT_CKE  = 6;
	localparam int STAT_FULL = 0;
	localparam int CON1_WCOL = 7;
	localparam int CON1_OVF  = 6;
	localparam int CON1_EN   = 5;
	localparam int CON1_CKP  = 4;
	localparam int CON3_OVW  = 4;
	localparam int EVT_FLAG  = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_CON1   = 8'h00;
	localparam logic [7:0] RST_CON3   = 8'h00;
	localparam logic [7:0] RST_DATA   = 8'h00;
	localparam logic [7:0] RST_RELOAD = 8'h00;

	// ==========================================================
	// Operating modes in the low nibble of control one
	localparam logic [3:0] MODE_M4     = 4'h0;
	localparam logic [3:0] MODE_M16    = 4'h1;
	localparam logic [3:0] MODE_M64    = 4'h2;
	localparam logic [3:0] MODE_MRLD   = 4'hA;
	localparam logic [3:0] MODE_S_SS   = 4'h4;
	localparam logic [3:0] MODE_S_NOSS = 4'h5;

	// ==========================================================
	// Half period of the master clock, in system cycles, and the index of the last of a byte's 16 clock edges
	localparam logic [DIV_W-1:0] HALF_M4  = 9'h002;
	localparam logic [DIV_W-1:0] HALF_M16 = 9'h008;
	localparam logic [DIV_W-1:0] HALF_M64 = 9'h020;
	localparam logic [EDGE_W-1:0] LAST_EDGE = 4'hF;

	// ==========================================================
	// Bus responses and shift engine states
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT} eng_state_t;

endpackage : spi_pkg

// File: stream_if.sv
/*
 * Valid/ready byte stream between the shift engine and the receive FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 8);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface : stream_if

// File: byte_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a power-of-two depth.
 */
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Streams
	stream_if.dst     fill,
	stream_if.src     drain
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW:0]      wr_q;
	logic [PW:0]      rd_q;
	logic             full;
	logic             empty;

	// ==========================================================
	// Flags
	assign empty       = (wr_q == rd_q);
	assign full        = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
	assign fill.ready  = !full;
	assign drain.valid = !empty;
	assign drain.data  = mem_q[rd_q[PW-1:0]];

	// ==========================================================
	// Pointers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (fill.valid && !full)
				wr_q <= wr_q + 1'b1;
			if (drain.ready && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end

	// Storage has no reset; a word is only read after it was written
	always_ff @(posedge clk)
	begin
		if (fill.valid && !full)
			mem_q[wr_q[PW-1:0]] <= fill.data;
	end

endmodule : byte_fifo

// File: spi_port_top.sv
/*
 * Serial port register file and byte shift engine with an AXI4-Lite
 * slave, master and slave clocking, and a receive FIFO ahead of the
 * data buffer. Assumes pins arrive asynchronously and the bench
 * resolves the two-way clock pin from sck_oe.
 */
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module spi_port_top
	import spi_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Serial pins
	input  wire logic              sck_i,
	output logic                   sck_o,
	output logic                   sck_oe,
	input  wire logic              sdi,
	output logic                   sdo,
	output logic                   sdo_oe,
	input  wire logic              ss_n
);

	// ==========================================================
	// Declarations
	logic [ADDR_W-1:0] awaddr_q;
	logic              aw_held_q;
	logic [7:0]        wbyte_q;
	logic              wstrb0_q;
	logic              w_held_q;
	logic              do_write;
	logic              wr_ok;
	logic              rd_ok;
	logic [7:0]        rd_val;
	logic              rd_take;

	logic              smp_q;
	logic              cke_q;
	logic              full_q;
	logic              wcol_q;
	logic              ovf_q;
	logic              en_q;
	logic              ckp_q;
	logic [3:0]        mode_q;
	logic [7:0]        con3_q;
	logic [DATA_W-1:0] buf_q;
	logic [7:0]        reload_q;
	logic              evt_q;

	logic              sck_s1_q, sck_s2_q, sck_s3_q;
	logic              sdi_s1_q, sdi_s2_q;
	logic              ss_s1_q, ss_s2_q;

	eng_state_t        state_q;
	logic [DIV_W-1:0]  div_q;
	logic [DIV_W-1:0]  half;
	logic              sck_q;
	logic [EDGE_W-1:0] edge_q;
	logic [DATA_W-1:0] shift_q;
	logic              sample_q;
	logic              sdo_q;

	logic              master;
	logic              slave;
	logic              selected;
	logic              tick;
	logic              lead;
	logic              trail;
	logic              any_edge;
	logic              sample_ev;
	logic              shift_ev;
	logic              done;
	logic              busy;
	logic              buf_wr;
	logic              buf_rd;
	logic              load;
	logic              collide;
	logic              pop;

	stream_if #(.WIDTH(DATA_W)) rx_in ();
	stream_if #(.WIDTH(DATA_W)) rx_out ();

	// ==========================================================
	// AXI4-Lite write channel
	assign awready  = !aw_held_q && !bvalid;
	assign wready   = !w_held_q && !bvalid;
	assign do_write = aw_held_q && w_held_q && !bvalid;

	always_comb
	begin
		case (awaddr_q)
			OFS_STATUS, OFS_CON1, OFS_CON3, OFS_DATA, OFS_RELOAD, OFS_EVENT: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_q <= 1'b0;
			awaddr_q  <= '0;
			w_held_q  <= 1'b0;
			wbyte_q   <= '0;
			wstrb0_q  <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= {awaddr[ADDR_W-1:2], 2'b00};
			end
			if (wvalid && wready)
			begin
				w_held_q <= 1'b1;
				wbyte_q  <= wdata[7:0];
				wstrb0_q <= wstrb[0];
			end
			if (do_write)
			begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	assign arready = !rvalid;
	assign rd_take = arvalid && arready;
	assign buf_rd  = rd_take && ({araddr[ADDR_W-1:2], 2'b00} == OFS_DATA);

	always_comb
	begin
		rd_ok = 1'b1;
		case ({araddr[ADDR_W-1:2], 2'b00})
			OFS_STATUS: rd_val = {smp_q, cke_q, 5'b0_0000, full_q};
			OFS_CON1:   rd_val = {wcol_q, ovf_q, en_q, ckp_q, mode_q};
			OFS_CON3:   rd_val = con3_q;
			OFS_DATA:   rd_val = buf_q;
			OFS_RELOAD: rd_val = reload_q;
			OFS_EVENT:  rd_val = {7'b000_0000, evt_q};
			default:
			begin
				rd_val = '0;
				rd_ok  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end
		else if (rd_take)
		begin
			rvalid <= 1'b1;
			rdata  <= {24'h00_0000, rd_val};
			rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end

	// ==========================================================
	// Registers
	assign buf_wr  = do_write && wstrb0_q && (awaddr_q == OFS_DATA);
	assign collide = buf_wr && busy;
	assign load    = buf_wr && !busy && en_q;
	// A bus write to the buffer takes priority over a FIFO pop in that cycle
	assign pop     = rx_out.valid && rx_out.ready;
	assign rx_out.ready = (!full_q || con3_q[CON3_OVW]) && !buf_wr;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			smp_q    <= RST_STATUS[STAT_SMP];
			cke_q    <= RST_STATUS[STAT_CKE];
			en_q     <= RST_CON1[CON1_EN];
			ckp_q    <= RST_CON1[CON1_CKP];
			mode_q   <= RST_CON1[3:0];
			con3_q   <= RST_CON3;
			reload_q <= RST_RELOAD;
		end
		else if (do_write && wstrb0_q)
		begin
			if (awaddr_q == OFS_STATUS)
			begin
				smp_q <= wbyte_q[STAT_SMP];
				cke_q <= wbyte_q[STAT_CKE];
			end
			if (awaddr_q == OFS_CON1)
			begin
				en_q   <= wbyte_q[CON1_EN];
				ckp_q  <= wbyte_q[CON1_CKP];
				mode_q <= wbyte_q[3:0];
			end
			if (awaddr_q == OFS_CON3)
				con3_q <= wbyte_q;
			if (awaddr_q == OFS_RELOAD)
				reload_q <= wbyte_q;
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wcol_q <= RST_CON1[CON1_WCOL];
			ovf_q  <= RST_CON1[CON1_OVF];
			evt_q  <= 1'b0;
		end
		else
		begin
			if (collide)
				wcol_q <= 1'b1;
			else if (do_write && wstrb0_q && awaddr_q == OFS_CON1)
				wcol_q <= wbyte_q[CON1_WCOL];
			if (done && !rx_in.ready)
				ovf_q <= 1'b1;
			else if (do_write && wstrb0_q && awaddr_q == OFS_CON1)
				ovf_q <= wbyte_q[CON1_OVF];
			if (pop)
				evt_q <= 1'b1;
			else if (do_write && wstrb0_q && awaddr_q == OFS_EVENT && wbyte_q[EVT_FLAG])
				evt_q <= 1'b0;
		end
	end

	// Full flag: set by a received byte, cleared by reading the buffer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			buf_q  <= RST_DATA;
			full_q <= 1'b0;
		end
		else if (load)
			buf_q <= wbyte_q;
		else if (pop)
		begin
			buf_q  <= rx_out.data;
			full_q <= 1'b1;
		end
		else if (buf_rd)
			full_q <= 1'b0;
	end

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{sck_s1_q, sck_s2_q, sck_s3_q} <= 3'b000;
			{sdi_s1_q, sdi_s2_q}           <= 2'b00;
			{ss_s1_q, ss_s2_q}             <= 2'b11;
		end
		else
		begin
			{sck_s1_q, sck_s2_q, sck_s3_q} <= {sck_i, sck_s1_q, sck_s2_q};
			{sdi_s1_q, sdi_s2_q}           <= {sdi, sdi_s1_q};
			{ss_s1_q, ss_s2_q}             <= {ss_n, ss_s1_q};
		end
	end

	// ==========================================================
	// Edge events
	assign master   = (mode_q == MODE_M4) || (mode_q == MODE_M16) || (mode_q == MODE_M64) || (mode_q == MODE_MRLD);
	assign slave    = (mode_q == MODE_S_SS) || (mode_q == MODE_S_NOSS);
	assign selected = (mode_q == MODE_S_NOSS) || !ss_s2_q;
	assign tick     = (state_q == ST_SHIFT) && (div_q == '0);

	always_comb
	begin
		lead  = 1'b0;
		trail = 1'b0;
		if (en_q && master && tick)
		begin
			lead  = (sck_q == ckp_q);
			trail = (sck_q != ckp_q);
		end
		else if (en_q && slave && selected && (sck_s2_q != sck_s3_q))
		begin
			lead  = (sck_s3_q == ckp_q);
			trail = (sck_s3_q != ckp_q);
		end
	end

	// With clock edge select set, data is sampled on the leading edge
	assign any_edge  = lead || trail;
	assign sample_ev = cke_q ? lead : trail;
	assign shift_ev  = cke_q ? trail : lead;
	assign done      = any_edge && (edge_q == LAST_EDGE);
	assign busy      = (state_q != ST_IDLE) || (edge_q != '0);
	assign rx_in.valid = done;
	assign rx_in.data  = {shift_q[DATA_W-2:0], cke_q ? sample_q : sdi_s2_q};

	always_comb
	begin
		case (mode_q)
			MODE_M16:  half = HALF_M16;
			MODE_M64:  half = HALF_M64;
			MODE_MRLD: half = {1'b0, reload_q} + 1'b1;
			default:   half = HALF_M4;
		endcase
	end

	// ==========================================================
	// Master sequencer; it waits for FIFO room so a finished byte is never lost
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			div_q   <= '0;
			sck_q   <= 1'b0;
		end
		else if (!en_q || !master)
		begin
			state_q <= ST_IDLE;
			sck_q   <= ckp_q;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					sck_q <= ckp_q;
					if (load)
						state_q <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (rx_in.ready)
					begin
						state_q <= ST_SHIFT;
						div_q   <= half - 1'b1;
					end
				end
				ST_SHIFT:
				begin
					if (tick)
					begin
						sck_q <= !sck_q;
						div_q <= half - 1'b1;
						if (done)
							state_q <= ST_IDLE;
					end
					else
						div_q <= div_q - 1'b1;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Shifter, shared by both directions
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			edge_q   <= '0;
			shift_q  <= '0;
			sample_q <= 1'b0;
			sdo_q    <= 1'b0;
		end
		else if (!en_q || (slave && !selected))
			edge_q <= '0;
		else
		begin
			if (load)
			begin
				shift_q <= wbyte_q;
				sdo_q   <= wbyte_q[DATA_W-1];
			end
			if (any_edge)
				edge_q <= edge_q + 1'b1;
			if (sample_ev)
				sample_q <= sdi_s2_q;
			if (shift_ev)
			begin
				shift_q <= {shift_q[DATA_W-2:0], sample_q};
				sdo_q   <= cke_q ? shift_q[DATA_W-2] : shift_q[DATA_W-1];
			end
		end
	end

	// ==========================================================
	// Receive FIFO and pins
	byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.clk   (clk),
		.rst_n (rst_n),
		.fill  (rx_in),
		.drain (rx_out)
	);

	assign sck_o  = sck_q;
	assign sck_oe = en_q && master;
	assign sdo    = sdo_q;
	assign sdo_oe = en_q && (master || (slave && selected));

endmodule : spi_port_top

// File: spi_port_checker.sv
/* Port checker for spi_port_top: bus handshakes and pin enables.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
module spi_port_checker
	import spi_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Register bus
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	// Pins
	input wire logic        sck_oe,
	input wire logic        sdo_oe
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence w_both; awvalid && awready && wvalid && wready; endsequence
	sequence b_done; bvalid && bready; endsequence
	a_w_answer: assert property (w_both |=> ##[0:1] bvalid)
		else $error("write answer late");
	a_b_release: assert property (b_done |=> !bvalid)
		else $error("write answer repeated");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_aw_block: assert property (bvalid |-> !awready && !wready)
		else $error("write taken during answer");
	a_r_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_ar_block: assert property (rvalid |-> !arready)
		else $error("read taken during answer");
	a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
		else $error("read data above byte");
	a_err_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0000_0000)
		else $error("error read carries data");
	a_oe_pair: assert property (sck_oe |-> sdo_oe)
		else $error("master clock without data out");
endmodule : spi_port_checker

// File: spi_peer.sv
/* SPI peer on the serial pins, clocked by the port in master mode.
   Assumes an idle-low clock and sampling on the leading edge. */
`timescale 1ns/1ps
module spi_peer
(
	// Serial pins
	input wire logic       sck,
	input wire logic       sdo,
	output logic           sdi,
	// Bench side
	input wire logic [7:0] tx_byte,
	output logic [7:0]     got_byte,
	output int             got_cnt
);
	// ==========================================================
	// Shifting
	logic [7:0] sh = 8'h00;
	logic [7:0] rx = 8'h00;
	int         bits = 0;
	initial got_cnt = 0;
	initial got_byte = 8'h00;
	// First bit must stand before the leading edge
	assign sdi = (bits == 0) ? tx_byte[7] : sh[7];
	always @(posedge sck)
	begin
		if (bits == 0) sh = tx_byte;
		rx = {rx[6:0], sdo};
		bits = bits + 1;
	end
	always @(negedge sck)
	begin
		sh = sh << 1;
		if (bits == 8)
		begin
			got_byte = rx;
			got_cnt = got_cnt + 1;
			bits = 0;
		end
	end
endmodule : spi_peer

// File: testbench.sv
/* Self-checking bench for spi_port_top: bus master tasks, SPI peer,
   queue model of the receive path. Assumes the package and peer come first. */
`timescale 1ns/1ps
module testbench import spi_pkg::*;;
	// ==========================================================
	// Signals
	logic        clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, peer_tx = 8'h00, got_byte;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, sdo, sdo_oe, sdi, sck_prev = 1'b0;
	logic        bready = 1'b0, rready = 1'b0, sck_line;
	logic [3:0]  wstrb = 4'hF;
	int          error_cnt = 0, check_count = 0, cyc = 0, got_cnt;
	int          stamps[$];
	logic [7:0]  exp_q[$];
	always #25 clk = ~clk;
	// Released clock line falls to its pull-down, so the peer never sees the idle level of a disabled port
	assign sck_line = sck_oe ? sck_o : 1'b0;
	spi_port_top uut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .sck_i(sck_line), .sck_o(sck_o), .sck_oe(sck_oe),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .ss_n(1'b1));
	spi_peer peer (.sck(sck_line), .sdo(sdo), .sdi(sdi), .tx_byte(peer_tx),
		.got_byte(got_byte), .got_cnt(got_cnt));
	// Clock edges are stamped in system cycles to measure the divider
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		sck_prev <= sck_o;
		if (sck_o !== sck_prev) stamps.push_back(cyc);
	end
	// ==========================================================
	// Tasks
	task automatic final_report;
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e)
		begin
			$display("unexpected at %0t: %s", $time, m);
			error_cnt++;
		end
	endtask : chk
	task automatic hang(input string m);
		chk(1'b0, 1'b1, m);
		final_report;
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b0;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid === 1'b1 && bready) break;
			// Answer accepted one cycle late so the response must hold
			if (bvalid === 1'b1) bready <= 1'b1;
		end
		r = bresp;
		if (n == 100) hang("write hang");
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b0;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid === 1'b1 && rready) break;
			if (rvalid === 1'b1) rready <= 1'b1;
		end
		d = rdata[7:0];
		r = rresp;
		if (n == 100) hang("read hang");
	endtask : rd
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string m);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk({r, d}, {RESP_OKAY, e}, m);
	endtask : rd_chk
	task automatic rd_pop;
		rd_chk(OFS_DATA, exp_q.pop_front(), "buffer order");
	endtask : rd_pop
	task automatic xfer(output logic [7:0] t, output int base);
		logic [7:0] p;
		logic [1:0] r;
		t = 8'($urandom);
		p = 8'($urandom);
		peer_tx <= p;
		// A buffer write replaces a received byte that software has not read yet
		if (exp_q.size() > 0) exp_q[0] = t;
		exp_q.push_back(p);
		base = stamps.size();
		wr(OFS_DATA, t, r);
	endtask : xfer
	task automatic fin(input int base, input int half, input logic [7:0] t);
		int n;
		for (n = 0; n < 3000 && stamps.size() < base + 16; n++) @(posedge clk);
		if (n == 3000) hang("serial clock stuck");
		chk(stamps[base + 15] - stamps[base], 15 * half, "clock rate");
		repeat (2) @(posedge clk);
		chk(got_byte, t, "peer byte");
	endtask : fin
	// ==========================================================
	// Sequence
	initial
	begin
		logic [7:0] d, t, v;
		logic [1:0] r;
		int         b, c, i;
		logic [3:0] modes[3];
		int         halves[3];
		void'($urandom(71));
		modes = '{MODE_M16, MODE_M64, MODE_MRLD};
		halves = '{int'(HALF_M16), int'(HALF_M64), 4};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk(OFS_STATUS, RST_STATUS, "status reset");
		rd_chk(OFS_CON1, RST_CON1, "control one reset");
		rd_chk(OFS_CON3, RST_CON3, "control three reset");
		rd_chk(OFS_RELOAD, RST_RELOAD, "reload reset");
		rd(8'h18, d, r);
		chk(r, RESP_SLVERR, "unmapped read");
		wr(8'h18, 8'hFF, r);
		chk(r, RESP_SLVERR, "unmapped write");
		wr(OFS_STATUS, 8'hFF, r);
		rd_chk(OFS_STATUS, 8'hC0, "status access");
		v = 8'($urandom) & 8'h1F;
		wr(OFS_CON1, v, r);
		rd_chk(OFS_CON1, v, "control one access");
		wr(OFS_STATUS, 8'h40, r);
		wr(OFS_RELOAD, 8'h03, r);
		wstrb <= 4'h0;
		wr(OFS_RELOAD, 8'h55, r);
		wstrb <= 4'hF;
		chk(r, RESP_OKAY, "masked write response");
		rd_chk(OFS_RELOAD, 8'h03, "masked write landed");
		for (i = 0; i < 3; i++)
		begin
			wr(OFS_CON1, 8'h00, r);
			wr(OFS_CON1, {4'h2, modes[i]}, r);
			chk(sck_oe, 1'b1, "clock not driven");
			xfer(t, b);
			rd_chk(OFS_DATA, t, "write missed buffer");
			wr(OFS_DATA, ~t, r);
			rd_chk(OFS_CON1, {4'hA, modes[i]}, "no collision flag");
			rd_chk(OFS_DATA, t, "buffer overwritten");
			fin(b, halves[i], t);
			rd_chk(OFS_EVENT, 8'h01, "event flag");
			rd_chk(OFS_STATUS, 8'h41, "full flag");
			rd_pop();
			wr(OFS_EVENT, 8'h01, r);
			rd_chk(OFS_EVENT, 8'h00, "event clear");
		end
		wr(OFS_CON1, 8'h00, r);
		wr(OFS_CON1, {4'h2, MODE_S_NOSS}, r);
		chk(sck_oe, 1'b0, "slave drives clock");
		wr(OFS_CON1, 8'h00, r);
		wr(OFS_CON1, {4'h2, MODE_M16}, r);
		// Buffer plus eight queued bytes, then one that must stall
		for (i = 0; i < 9; i++)
		begin
			xfer(t, b);
			fin(b, halves[0], t);
		end
		xfer(t, b);
		c = got_cnt;
		repeat (300) @(posedge clk);
		chk(got_cnt, c, "shift while queue full");
		rd_pop();
		fin(b, halves[0], t);
		repeat (9) rd_pop();
		rd_chk(OFS_STATUS, 8'h40, "full after drain");
		final_report();
	end
endmodule : testbench

bind spi_port_top spi_port_checker checks (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sck_oe(sck_oe),
	.sdo_oe(sdo_oe));
